// file: verilog/reset_startup_and_cause_flags.sv
// reset sequencer: start-up gating and reset-cause flag registers
// assumes watchdog and core deliver one-cycle event pulses on i_mclk;
// supply and oscillator inputs are levels; the reset pin is asynchronous
//
// Contract
// - programming-mode exit acts as power-on reset
// - self-programming never resets the device
// - enabled delay holds reset 64 ms
// - delay enable is active low
// - delay counts after power-on and brown-out release
// - run needs delay, oscillator, pin released
// - timers run while pin held low
// - execution starts 10 cycles after pin release
// - resets load vector 0000h, wake continues
// - interrupt wake with enable goes to 0004h
// - only occurring cause flag changes
// - software flag writes cause no reset
// - stack fault flags set, firmware clears
// - window violation clears its flag
// - watchdog reset clears its flag
// - pin and instruction resets clear flags
// - power-on clears both, brown-out clears one
// - timeout and powerdown bits track sleep events
// - pin reset enabled by enable or programming
// - low pin holds reset, short pulses filtered
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module reset_startup_and_cause_flags
  import rst_seq_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_DELAY_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // supply and configuration
  input wire logic i_power_on_reset,
  input wire logic i_brownout_reset,
  input wire logic i_power_up_delay_enable_n,
  input wire logic i_reset_pin_enable,
  input wire logic i_low_voltage_programming,
  input wire logic i_stack_fault_reset_enable,
  input wire logic i_serial_programming_mode,
  input wire logic i_brownout_ready,
  // oscillator start-up
  input wire logic i_osc_startup_needed,
  input wire logic i_osc_startup_done,
  // external reset pin (asynchronous)
  input wire logic i_external_reset_pin,
  // reset and wake events, one-cycle pulses, plus the interrupt enable level
  input wire logic i_watchdog_timeout,
  input wire logic i_window_violation,
  input wire logic i_reset_instr,
  input wire logic i_stack_overflow,
  input wire logic i_stack_underflow,
  input wire logic i_sleep_enter,
  input wire logic i_wake_watchdog,
  input wire logic i_wake_interrupt,
  input wire logic i_global_int_enable,
  input wire logic i_self_program,
  // register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // core control
  output logic o_core_reset,
  output logic o_pin_as_input,
  output logic o_load_pc,
  output logic [15:0] o_pc_value,
  output logic [7:0] o_watchdog_control
);
  // -----------------------------------------------------------------
  // pin synchroniser and glitch filter
  // -----------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;
  logic pin_filt;
  logic [2:0] filt_cnt;
  wire pin_function_on = i_reset_pin_enable | i_low_voltage_programming;
  wire pin_differs = pin_sync != pin_filt;
  // two stages before anything looks at the pin
  always_ff @(posedge i_mclk) begin
    pin_meta <= i_external_reset_pin;
    pin_sync <= pin_meta;
  end
  // level must hold for several cycles before the filter follows it
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pin_filt <= 1'b1;
      filt_cnt <= 3'h0;
    end else if (!pin_differs) begin
      filt_cnt <= 3'h0;
    end else if (filt_cnt == 3'(PIN_FILTER_CYCLES - 1)) begin
      pin_filt <= pin_sync;
      filt_cnt <= 3'h0;
    end else begin
      filt_cnt <= filt_cnt + 3'h1;
    end
  end
  wire pin_low = pin_function_on & ~pin_filt;
  assign o_pin_as_input = ~pin_function_on;
  // -----------------------------------------------------------------
  // start-up sequencer
  // -----------------------------------------------------------------
  seq_state_type state;
  seq_state_type next_state;
  logic [CNT_W-1:0] delay_cnt;
  logic [3:0] rel_cnt;
  logic in_sleep;
  logic prog_prev;
  wire prog_exit = prog_prev & ~i_serial_programming_mode;
  wire cold = i_power_on_reset | prog_exit;
  wire supply_low = cold | i_brownout_reset | i_serial_programming_mode;
  // stack faults only reset when the configuration allows it
  wire stack_rst = i_stack_fault_reset_enable &
    (i_stack_overflow | i_stack_underflow);
  // self-programming is deliberately absent from the warm set
  wire warm = i_watchdog_timeout | i_window_violation | i_reset_instr |
    stack_rst;
  wire delay_done = i_power_up_delay_enable_n |
    (delay_cnt == CNT_W'(POWER_UP_CYCLES - 1));
  wire osc_ok = ~i_osc_startup_needed | i_osc_startup_done;
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD:
        if (!supply_low) next_state = ST_DELAY;
      ST_DELAY:
        if (delay_done && osc_ok) next_state = ST_WAIT_PIN;
      ST_WAIT_PIN:
        if (!pin_low) next_state = ST_RELEASE;
      ST_RELEASE:
        if (pin_low) next_state = ST_WAIT_PIN;
        else if (rel_cnt == 4'(RELEASE_CYCLES - 1)) next_state = ST_RUN;
      ST_RUN:
        if (pin_low || warm) next_state = ST_WAIT_PIN;
      default: next_state = ST_HOLD;
    endcase
    if (supply_low) next_state = ST_HOLD;
  end
  // delay counter runs regardless of the pin level
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state <= ST_HOLD;
      delay_cnt <= '0;
      rel_cnt <= 4'h0;
      prog_prev <= 1'b0;
    end else begin
      state <= next_state;
      prog_prev <= i_serial_programming_mode;
      delay_cnt <= (state != ST_DELAY) ? '0 :
        delay_done ? delay_cnt : delay_cnt + CNT_W'(1);
      rel_cnt <= (state == ST_RELEASE) ? rel_cnt + 4'h1 : 4'h0;
    end
  end
  assign o_core_reset = state != ST_RUN;
  // -----------------------------------------------------------------
  // program counter steering
  // -----------------------------------------------------------------
  wire run_start = state == ST_RELEASE && next_state == ST_RUN;
  wire int_vector = in_sleep & i_wake_interrupt & i_global_int_enable;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_load_pc <= 1'b0;
      o_pc_value <= VECTOR_RESET;
    end else begin
      o_load_pc <= run_start | int_vector;
      o_pc_value <= int_vector ? VECTOR_INTERRUPT : VECTOR_RESET;
    end
  end
  // -----------------------------------------------------------------
  // cause flags: set and clear per bit
  // -----------------------------------------------------------------
  logic [7:0] flags;
  logic [7:0] status;
  logic sw_bor_en;
  wire wr_flags = i_wr && i_addr == ADDR_POWER_CONTROL_FLAGS;
  wire wr_status = i_wr && i_addr == ADDR_CORE_STATUS;
  wire pin_fall = state == ST_RUN && pin_low;
  wire pin_in_sleep = in_sleep & pin_low;
  logic [7:0] hw_set;
  logic [7:0] hw_clr;
  always_comb begin
    hw_set = 8'h00;
    hw_clr = 8'h00;
    hw_set[BIT_STACK_OVF] = i_stack_overflow;
    hw_set[BIT_STACK_UNF] = i_stack_underflow;
    hw_clr[BIT_WINDOW_N] = i_window_violation;
    hw_clr[BIT_WDOG_N] = i_watchdog_timeout;
    hw_clr[BIT_PIN_N] = pin_fall | pin_in_sleep;
    hw_clr[BIT_INSTR_N] = i_reset_instr;
    hw_clr[BIT_POR_N] = cold;
    hw_clr[BIT_BOR_N] = cold | i_brownout_reset;
  end
  // hardware events win over a same-cycle software write
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_flag
      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) flags[b] <= FLAGS_POR_VALUE[b];
        else if (hw_set[b]) flags[b] <= 1'b1;
        else if (hw_clr[b]) flags[b] <= 1'b0;
        else if (wr_flags) flags[b] <= i_wdata[b];
      end
    end
  endgenerate
  // timeout and powerdown bits; sleep tracker
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      status <= 8'h18;
      in_sleep <= 1'b0;
    end else begin
      if (cold) begin
        status[BIT_TIMEOUT_N] <= 1'b1;
        status[BIT_POWERDOWN_N] <= 1'b1;
      end else begin
        if (i_watchdog_timeout || (in_sleep && i_wake_watchdog))
          status[BIT_TIMEOUT_N] <= 1'b0;
        else if (wr_status) status[BIT_TIMEOUT_N] <= i_wdata[BIT_TIMEOUT_N];
        if (i_sleep_enter) status[BIT_POWERDOWN_N] <= 1'b0;
        else if (wr_status)
          status[BIT_POWERDOWN_N] <= i_wdata[BIT_POWERDOWN_N];
      end
      if (supply_low || pin_low || (in_sleep &&
          (i_wake_watchdog || i_wake_interrupt)))
        in_sleep <= 1'b0;
      else if (i_sleep_enter) in_sleep <= 1'b1;
    end
  end
  // software brownout enable and watchdog control storage
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sw_bor_en <= 1'b1;
      o_watchdog_control <= WDOG_CTRL_RESET;
    end else begin
      if (i_wr && i_addr == ADDR_BROWNOUT_CONTROL)
        sw_bor_en <= i_wdata[BIT_SW_BOR_EN];
      if (i_wr && i_addr == ADDR_WATCHDOG_CONTROL)
        o_watchdog_control <= i_wdata;
    end
  end
  // -----------------------------------------------------------------
  // read port: data in the cycle after the strobe
  // -----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (i_addr)
      ADDR_BROWNOUT_CONTROL: begin
        rd_mux[BIT_SW_BOR_EN] = sw_bor_en;
        rd_mux[BIT_BOR_READY] = i_brownout_ready;
      end
      ADDR_POWER_CONTROL_FLAGS: rd_mux = flags;
      ADDR_CORE_STATUS: begin
        rd_mux[BIT_TIMEOUT_N] = status[BIT_TIMEOUT_N];
        rd_mux[BIT_POWERDOWN_N] = status[BIT_POWERDOWN_N];
      end
      ADDR_WATCHDOG_CONTROL: rd_mux = o_watchdog_control;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) o_rdata <= 8'h00;
    else o_rdata <= i_rd ? rd_mux : 8'h00;
  end
  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  int unsigned release_wait;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || state != ST_RELEASE) release_wait <= 0;
    else release_wait <= release_wait + 1;
  end
  release_count_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $rose(state == ST_RUN) |-> $past(release_wait) == RELEASE_CYCLES - 1)
    else $error("release did not take ten cycles");
  hold_in_reset_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    supply_low |=> o_core_reset [*2])
    else $error("core left reset during supply hold");
  delay_start_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state == ST_HOLD && !supply_low |=> state == ST_DELAY)
    else $error("delay not started after supply release");
  delay_bypass_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state == ST_DELAY && i_power_up_delay_enable_n && osc_ok && !supply_low
    |=> state == ST_WAIT_PIN)
    else $error("disabled delay still waited");
  pin_holds_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    pin_low |=> o_core_reset)
    else $error("core ran with reset pin low");
  por_flags_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    cold |=> !flags[BIT_POR_N] && !flags[BIT_BOR_N])
    else $error("power-on flags not cleared");
  wdog_flag_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_watchdog_timeout |=> !flags[BIT_WDOG_N] && !status[BIT_TIMEOUT_N])
    else $error("watchdog flags not cleared");
  stack_flag_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_stack_overflow |=> flags[BIT_STACK_OVF])
    else $error("overflow flag not set");
  flag_keep_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !wr_flags && hw_set == 8'h00 && hw_clr == 8'h00 |=> $stable(flags))
    else $error("flag changed without cause");
  int_vector_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    int_vector |=> o_load_pc && o_pc_value == VECTOR_INTERRUPT)
    else $error("interrupt vector not loaded");
  // cycles spent in the delay state, held at zero elsewhere
  int unsigned delay_wait;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || state != ST_DELAY) delay_wait <= 0;
    else delay_wait <= delay_wait + 1;
  end
  delay_hold_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    state == ST_DELAY && next_state == ST_WAIT_PIN &&
    !i_power_up_delay_enable_n |-> delay_wait >= POWER_UP_CYCLES - 1)
    else $error("power-up delay cut short");
  self_prog_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_self_program && state == ST_RUN && !warm && !pin_low &&
    !supply_low |=> state == ST_RUN)
    else $error("self programming reset the core");
  flag_write_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    wr_flags && state == ST_RUN && !warm && !pin_low &&
    !supply_low |=> !o_core_reset)
    else $error("flag write reset the core");
  // with the stack reset disabled a fault only marks its flag
  stack_off_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    state == ST_RUN && !i_stack_fault_reset_enable && !pin_low &&
    !supply_low && !i_watchdog_timeout && !i_window_violation &&
    !i_reset_instr |=> state == ST_RUN)
    else $error("stack fault reset while disabled");
  reset_vector_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    run_start && !int_vector |=> o_load_pc &&
    o_pc_value == VECTOR_RESET)
    else $error("reset vector not loaded");
  window_flag_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_window_violation |=> !flags[BIT_WINDOW_N])
    else $error("window flag not cleared");
  instr_flag_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_reset_instr |=> !flags[BIT_INSTR_N])
    else $error("instruction flag not cleared");
  pin_flag_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    pin_fall |=> !flags[BIT_PIN_N])
    else $error("pin flag not cleared");
  bor_flag_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_brownout_reset |=> !flags[BIT_BOR_N])
    else $error("brownout flag not cleared");
  under_flag_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_stack_underflow |=> flags[BIT_STACK_UNF])
    else $error("underflow flag not set");
  sleep_pd_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_sleep_enter && !cold |=> !status[BIT_POWERDOWN_N])
    else $error("powerdown bit not cleared");
  wake_to_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    in_sleep && i_wake_watchdog && !cold |=> !status[BIT_TIMEOUT_N])
    else $error("timeout bit not cleared on wake");
  cold_status_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    cold |=> status[BIT_TIMEOUT_N] &&
    status[BIT_POWERDOWN_N])
    else $error("status bits not set on cold start");
  // a filtered edge needs four equal samples behind it
  pin_filter_a: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    $changed(pin_filt) |-> $past(pin_sync) == pin_filt &&
    $past(pin_sync, 4) == pin_filt)
    else $error("pin filter passed a short pulse");
  run_cover_c: cover property (@(posedge i_mclk) $rose(state == ST_RUN));
  wdog_cover_c: cover property (@(posedge i_mclk) i_watchdog_timeout);
  wake_cover_c: cover property (@(posedge i_mclk) int_vector);
  pin_cover_c: cover property (@(posedge i_mclk) pin_fall);
  prog_cover_c: cover property (@(posedge i_mclk) prog_exit);
endmodule : reset_startup_and_cause_flags
`default_nettype wire

// file: verilog/rst_seq_pkg.sv
// constants for the reset sequencer and reset-cause flag block
// assumes a 20 MHz system clock and a plain strobe register port
package rst_seq_pkg;
  // ---------------------------------------------------------------
  // register map (offsets chosen for this block)
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_BROWNOUT_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_POWER_CONTROL_FLAGS = 2'h1;
  localparam logic [1:0] ADDR_CORE_STATUS = 2'h2;
  localparam logic [1:0] ADDR_WATCHDOG_CONTROL = 2'h3;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_STACK_OVF = 7;
  localparam int BIT_STACK_UNF = 6;
  localparam int BIT_WINDOW_N = 5;
  localparam int BIT_WDOG_N = 4;
  localparam int BIT_PIN_N = 3;
  localparam int BIT_INSTR_N = 2;
  localparam int BIT_POR_N = 1;
  localparam int BIT_BOR_N = 0;
  localparam int BIT_TIMEOUT_N = 4;
  localparam int BIT_POWERDOWN_N = 3;
  localparam int BIT_SW_BOR_EN = 7;
  localparam int BIT_BOR_READY = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAGS_POR_VALUE = 8'h3C;
  localparam logic [7:0] WDOG_CTRL_RESET = 8'h00;
  localparam logic [15:0] VECTOR_RESET = 16'h0000;
  localparam logic [15:0] VECTOR_INTERRUPT = 16'h0004;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int POWER_UP_DELAY_MS = 64;
  localparam int POWER_UP_DELAY_CYCLES = POWER_UP_DELAY_MS * (CLK_HZ / 1000);
  localparam int RELEASE_CYCLES = 10;
  localparam int PIN_FILTER_CYCLES = 4;
  localparam int CNT_W = 24;
  typedef enum logic [2:0] {ST_HOLD, ST_DELAY, ST_WAIT_PIN, ST_RELEASE,
    ST_RUN} seq_state_type;
endpackage : rst_seq_pkg

// file: verif/supply_pin_model.sv
// partner model: supply detectors and the external reset pin
// assumes the bench steers supply and pin by levels changed at clock edges
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
  // bench commands
  input wire logic i_supply_low,
  input wire logic i_supply_sag,
  input wire logic i_pin_pull_low,
  // detectors and pin toward the block
  output logic o_power_on_reset,
  output logic o_brownout_reset,
  output logic o_external_reset_pin
);
  // ------------------------------------------------------------
  // supply detectors and pin
  // ------------------------------------------------------------
  // detector levels follow the supply directly, no hysteresis modelled
  assign o_power_on_reset = i_supply_low;
  assign o_brownout_reset = i_supply_sag;
  // weak pull-up: a released pin reads high, never a stale value
  assign o_external_reset_pin = i_pin_pull_low ? 1'b0 : 1'b1;
endmodule : supply_pin_model
`default_nettype wire

// file: verif/testbench.sv
// bench for the reset sequencer: cold and warm starts, cause flags
// assumes the design package and the supply/pin partner model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rst_seq_pkg::*;
  localparam int PU = 40;
  // window flag may also take the watchdog bit, so bit 4 is masked there
  localparam logic [7:0] EV_M [5] = '{8'hEF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] EV_V [5] = '{8'h1F, 8'h2F, 8'h3B, 8'hBF, 8'h7F};
  logic mclk, sys_rst, supply_low, supply_sag, pin_low, pin_en, low_voltage_programming, global_int_enable;
  logic delay_en_n, stk_en, spm, brownout_ready, osc_need, osc_done;
  logic wr, rd, rd_d, on_rst, sag_rst, pin;
  logic core_reset, pin_as_input, load_pc;
  logic [8:0] ev;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, wd_ctrl, rnd;
  logic [15:0] pc_value, ent;
  logic [15:0] expq[$];
  logic [15:0] pcq[$];
  int error_cnt, comparisons, seed, i;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  supply_pin_model model (.i_supply_low(supply_low),
    .i_supply_sag(supply_sag), .i_pin_pull_low(pin_low),
    .o_power_on_reset(on_rst), .o_brownout_reset(sag_rst),
    .o_external_reset_pin(pin));
  reset_startup_and_cause_flags #(.POWER_UP_CYCLES(PU)) dut (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_power_on_reset(on_rst),
    .i_brownout_reset(sag_rst), .i_power_up_delay_enable_n(delay_en_n),
    .i_reset_pin_enable(pin_en), .i_low_voltage_programming(low_voltage_programming),
    .i_stack_fault_reset_enable(stk_en), .i_serial_programming_mode(spm),
    .i_brownout_ready(brownout_ready), .i_osc_startup_needed(osc_need),
    .i_osc_startup_done(osc_done), .i_external_reset_pin(pin),
    .i_watchdog_timeout(ev[1]), .i_window_violation(ev[0]),
    .i_reset_instr(ev[2]), .i_stack_overflow(ev[3]),
    .i_stack_underflow(ev[4]), .i_sleep_enter(ev[5]),
    .i_wake_watchdog(ev[6]), .i_wake_interrupt(ev[7]),
    .i_global_int_enable(global_int_enable), .i_self_program(ev[8]), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_core_reset(core_reset), .o_pin_as_input(pin_as_input),
    .o_load_pc(load_pc), .o_pc_value(pc_value),
    .o_watchdog_control(wd_ctrl));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic results;
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // note mask and value; the monitor compares the answer
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] m,
    input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back({m, e});
    @(posedge mclk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic pulse(input int k);
    @(posedge mclk);
    ev[k] <= 1'b1;
    @(posedge mclk);
    ev <= '0;
  endtask : pulse
  // settle past the edge so the state register has landed
  task automatic held(input logic v, input string m);
    #1;
    check(core_reset === v, m);
  endtask : held
  // core must be held now, then released within lo..hi cycles
  task automatic wait_run(input int lo, input int hi);
    int n;
    n = 0;
    held(1'b1, "core not held");
    while (core_reset !== 1'b0 && n <= hi) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(n >= lo && n <= hi, "release time");
  endtask : wait_run

  // monitor: read answers and program counter loads against the notes
  always @(posedge mclk) begin
    rd_d <= rd;
    if (rd_d === 1'b1) begin
      if (expq.size() == 0) check(1'b0, "read without note");
      else begin
        ent = expq.pop_front();
        check((rdata & ent[15:8]) === (ent[7:0] & ent[15:8]), "read data");
      end
    end
    if (load_pc === 1'b1) begin
      if (pcq.size() == 0) check(1'b0, "unexpected pc load");
      else check(pc_value === pcq.pop_front(), "pc value");
    end
  end

  // watchdog: whole run is a few hundred cycles, limit is 20000
  initial begin
    #(50 * 20000);
    error_cnt++;
    results();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 82994;
    {sys_rst, supply_low, supply_sag, pin_low, pin_en, low_voltage_programming, global_int_enable} = 7'h64;
    {delay_en_n, stk_en, spm, brownout_ready, osc_need, osc_done} = 6'h10;
    {wr, rd, ev, addr, wdata, error_cnt, comparisons} = '0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (50) @(posedge mclk);
    pcq.push_back(VECTOR_RESET);
    supply_low <= 1'b0;
    wait_run(PU, PU + 30);
    rd_reg(ADDR_POWER_CONTROL_FLAGS, 8'hFF, FLAGS_POR_VALUE);
    rd_reg(ADDR_CORE_STATUS, 8'h18, 8'h18);
    wr_reg(ADDR_POWER_CONTROL_FLAGS, 8'hC0);
    rd_reg(ADDR_POWER_CONTROL_FLAGS, 8'hFF, 8'hC0);
    wr_reg(ADDR_POWER_CONTROL_FLAGS, 8'h3F);
    held(1'b0, "flag write caused reset");
    // warm reset causes, firmware restores flags after each
    for (i = 0; i < 5; i++) begin
      pcq.push_back(VECTOR_RESET);
      pulse(i);
      wait_run(10, 30);
      rd_reg(ADDR_POWER_CONTROL_FLAGS, EV_M[i], EV_V[i]);
      wr_reg(ADDR_POWER_CONTROL_FLAGS, 8'h3F);
    end
    rd_reg(ADDR_CORE_STATUS, 8'h10, 8'h00);
    // pin: one-cycle glitch ignored, long low resets
    @(posedge mclk);
    pin_low <= 1'b1;
    @(posedge mclk);
    pin_low <= 1'b0;
    repeat (12) @(posedge mclk);
    held(1'b0, "short pin pulse reset");
    pcq.push_back(VECTOR_RESET);
    @(posedge mclk);
    pin_low <= 1'b1;
    repeat (12) @(posedge mclk);
    pin_low <= 1'b0;
    wait_run(10, 30);
    rd_reg(ADDR_POWER_CONTROL_FLAGS, 8'hFF, 8'h37);
    wr_reg(ADDR_POWER_CONTROL_FLAGS, 8'h3F);
    // sleep and wake
    wr_reg(ADDR_CORE_STATUS, 8'h18);
    pulse(5);
    rd_reg(ADDR_CORE_STATUS, 8'h18, 8'h10);
    global_int_enable <= 1'b1;
    pcq.push_back(VECTOR_INTERRUPT);
    pulse(7);
    held(1'b0, "wake caused reset");
    pulse(5);
    global_int_enable <= 1'b0;
    pulse(7);
    rd_reg(ADDR_CORE_STATUS, 8'h18, 8'h10);
    pulse(5);
    pulse(6);
    rd_reg(ADDR_CORE_STATUS, 8'h18, 8'h00);
    pulse(8);
    repeat (4) @(posedge mclk);
    held(1'b0, "self program reset");
    rd_reg(ADDR_POWER_CONTROL_FLAGS, 8'hFF, 8'h3F);
    // pin function off, then back on by low-voltage programming
    pin_en <= 1'b0;
    pin_low <= 1'b1;
    repeat (12) @(posedge mclk);
    held(1'b0, "disabled pin reset");
    check(pin_as_input === 1'b1, "pin not general input");
    @(posedge mclk);
    pin_low <= 1'b0;
    repeat (12) @(posedge mclk);
    low_voltage_programming <= 1'b1;
    #1;
    check(pin_as_input === 1'b0, "pin not enabled by lvp");
    // programming mode exit acts as a cold start
    @(posedge mclk);
    {pin_en, low_voltage_programming, spm} <= 3'b101;
    repeat (3) @(posedge mclk);
    spm <= 1'b0;
    pcq.push_back(VECTOR_RESET);
    @(posedge mclk);
    wait_run(PU, PU + 30);
    rd_reg(ADDR_POWER_CONTROL_FLAGS, 8'h03, 8'h00);
    wr_reg(ADDR_POWER_CONTROL_FLAGS, 8'h3F);
    // brown-out with the delay bypassed
    delay_en_n <= 1'b1;
    supply_sag <= 1'b1;
    pcq.push_back(VECTOR_RESET);
    repeat (3) @(posedge mclk);
    supply_sag <= 1'b0;
    wait_run(8, PU - 5);
    rd_reg(ADDR_POWER_CONTROL_FLAGS, 8'h03, 8'h02);
    // brown-out, pin held low past both timers
    {delay_en_n, osc_need, osc_done, pin_low, supply_sag} <= 5'b01011;
    pcq.push_back(VECTOR_RESET);
    repeat (3) @(posedge mclk);
    supply_sag <= 1'b0;
    repeat (PU + 20) @(posedge mclk);
    osc_done <= 1'b1;
    repeat (10) @(posedge mclk);
    held(1'b1, "ran with pin low");
    @(posedge mclk);
    pin_low <= 1'b0;
    wait_run(10, 30);
    // brown-out with the oscillator still starting
    @(posedge mclk);
    {osc_done, supply_sag} <= 2'b01;
    pcq.push_back(VECTOR_RESET);
    repeat (3) @(posedge mclk);
    supply_sag <= 1'b0;
    repeat (PU + 30) @(posedge mclk);
    held(1'b1, "ran before oscillator ready");
    @(posedge mclk);
    osc_done <= 1'b1;
    wait_run(8, 30);
    // stack fault with its reset disabled: flag only
    stk_en <= 1'b0;
    pulse(3);
    held(1'b0, "stack fault reset while disabled");
    rd_reg(ADDR_POWER_CONTROL_FLAGS, 8'h80, 8'h80);
    // random register traffic
    for (i = 0; i < 4; i++) begin
      rnd = 8'($random(seed));
      brownout_ready <= rnd[0];
      wr_reg(ADDR_WATCHDOG_CONTROL, rnd);
      rd_reg(ADDR_WATCHDOG_CONTROL, 8'hFF, rnd);
      check(wd_ctrl === rnd, "watchdog control out");
      wr_reg(ADDR_BROWNOUT_CONTROL, rnd);
      rd_reg(ADDR_BROWNOUT_CONTROL, 8'hFF, {rnd[7], 6'h00, rnd[0]});
    end
    repeat (5) @(posedge mclk);
    check(pcq.size() == 0, "pc load missing");
    results();
  end
endmodule : testbench
`default_nettype wire
